/* core/level_sync.v */
`timescale 1ns/1ns
`default_nettype none
// ************************************
// Two-stage synchroniser, per bit
// ************************************
module level_sync
#(
   parameter WIDTH = 1
)
(
   input wire clock,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage_one;
   always @(posedge clock)
   begin
      stage_one <= async_in;
      sync_out <= stage_one;
   end
endmodule
`default_nettype wire

/* core/reset_and_clock_source_control.v */
`timescale 1ns/1ns
`default_nettype none
`include "reset_clock_consts.vh"
module reset_and_clock_source_control
(
   input wire clock,
   input wire srst,
   input wire power_on_reset,
   input wire supply_monitor_enable_pin,
   input wire supply_low,
   input wire watchdog_expired,
   input wire missing_clock,
   input wire comparator_zero,
   input wire conversion_start_pin_zero,
   input wire reset_pin_in,
   output wire reset_pin_out,
   output wire reset_pin_oe_n,
   output reg system_reset,
   output reg clock_select_external,
   output wire watchdog_enable,
   output wire interrupt,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o
);
   // ************************************
   // Pin synchronisers
   // ************************************
   wire [5:0] pins_sync;
   level_sync #(.WIDTH(6)) u_sync
   (
      .clock(clock),
      .async_in({supply_monitor_enable_pin, supply_low, missing_clock,
                 comparator_zero, conversion_start_pin_zero, reset_pin_in}),
      .sync_out(pins_sync)
   );
   wire mon_en = pins_sync[5];
   wire supply_low_s = pins_sync[4];
   wire missing_s = pins_sync[3];
   wire comp_s = pins_sync[2];
   wire conv_s = pins_sync[1];
   wire pin_low_s = ~pins_sync[0];
   // ************************************
   // Software state
   // ************************************
   reg [6:0] source_enable;
   reg [6:0] event_status;
   reg [6:0] event_mask;
   reg [6:0] last_cause;
   reg sw_reset_req;
   reg wdog_locked;
   reg [3:0] stretch;
   // Load value cut to counter width on purpose
   wire [31:0] stretch_full = `STRETCH_CYCLES;
   wire [6:0] raw_sources;
   wire [6:0] active;
   // Open-drain pin: drive low only during power-up reset
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe_n = ~power_on_reset;
   assign raw_sources[`SRC_SUPPLY] = supply_low_s & mon_en;
   assign raw_sources[`SRC_WATCHDOG] = watchdog_expired;
   assign raw_sources[`SRC_MISSING_CLOCK] = missing_s;
   assign raw_sources[`SRC_COMPARATOR] = comp_s;
   assign raw_sources[`SRC_SOFTWARE] = sw_reset_req;
   assign raw_sources[`SRC_CONVERSION] = conv_s;
   assign raw_sources[`SRC_PIN] = pin_low_s;
   // Supply and pin bits are forced on regardless of the mask
   // Locked watchdog cannot be masked
   wire [6:0] eff_enable = source_enable |
      (7'h01 << `SRC_SUPPLY) | (7'h01 << `SRC_PIN) |
      ({6'h00, wdog_locked} << `SRC_WATCHDOG);
   assign active = raw_sources & eff_enable;
   // Watchdog cannot be masked once locked
   assign watchdog_enable = eff_enable[`SRC_WATCHDOG];
   assign interrupt = |(event_status & event_mask);
   // ************************************
   // Reset generation
   // ************************************
   // Stretch keeps reset a few cycles past the last source
   always @(posedge clock)
   begin
      if (srst | power_on_reset)
      begin
         system_reset <= 1'b1;
         stretch <= 4'h0;
      end
      else if (|active)
      begin
         system_reset <= 1'b1;
         stretch <= stretch_full[3:0];
      end
      else if (stretch != 4'h0)
         stretch <= stretch - 4'h1;
      else
         system_reset <= 1'b0;
   end
   // ************************************
   // Wishbone slave and registers
   // ************************************
   wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   wire rd = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   always @(posedge clock)
   begin
      if (srst | power_on_reset)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= rd;
         wb_dat_o <= 32'h0000_0000;
         if (rd & ~wb_we_i)
            case (wb_adr_i)
               `REG_CONTROL: wb_dat_o <= {29'h0000_0000, wdog_locked,
                  sw_reset_req, clock_select_external};
               `REG_SOURCE_ENABLE: wb_dat_o <= {25'h000_0000, eff_enable};
               `REG_SOURCE_STATUS: wb_dat_o <= {25'h000_0000, last_cause};
               `REG_EVENT_STATUS: wb_dat_o <= {25'h000_0000, event_status};
               `REG_EVENT_MASK: wb_dat_o <= {25'h000_0000, event_mask};
               `REG_LIVE: wb_dat_o <= {25'h000_0000, raw_sources};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
      end
   end
   // Control state: power-on clears the watchdog lock, any reset the rest
   always @(posedge clock)
   begin
      if (power_on_reset)
      begin
         wdog_locked <= 1'b0;
      end
      else if (wr && wb_adr_i == `REG_CONTROL
               && wb_dat_i[`CTRL_WDOG_LOCK_BIT])
         wdog_locked <= 1'b1;
   end
   always @(posedge clock)
   begin
      if (srst | system_reset)
      begin
         clock_select_external <= 1'b0;
         sw_reset_req <= 1'b0;
         source_enable <= `SOURCE_ENABLE_RESET;
         event_mask <= `EVENT_MASK_RESET;
      end
      else if (wr)
         case (wb_adr_i)
            `REG_CONTROL:
            begin
               clock_select_external <= wb_dat_i[`CTRL_CLOCK_SEL_BIT];
               sw_reset_req <= wb_dat_i[`CTRL_SW_RESET_BIT];
            end
            `REG_SOURCE_ENABLE: source_enable <= wb_dat_i[6:0];
            `REG_EVENT_MASK: event_mask <= wb_dat_i[6:0];
            default: source_enable <= source_enable;
         endcase
   end
   // Cause capture survives the reset it caused; set wins over clear
   always @(posedge clock)
   begin
      if (srst | power_on_reset)
      begin
         event_status <= 7'h00;
         last_cause <= 7'h00;
      end
      else
      begin
         if (|active)
            last_cause <= active;
         if (wr && wb_adr_i == `REG_EVENT_STATUS)
            event_status <= (event_status & ~wb_dat_i[6:0]) | active;
         else
            event_status <= event_status | active;
      end
   end
endmodule
`default_nettype wire

/* core/reset_clock_consts.vh */
`ifndef RESET_CLOCK_CONSTS_VH
`define RESET_CLOCK_CONSTS_VH
// ************************************
// Register offsets (byte addresses)
// ************************************
`define REG_CONTROL 8'h00
`define REG_SOURCE_ENABLE 8'h04
`define REG_SOURCE_STATUS 8'h08
`define REG_EVENT_STATUS 8'h0C
`define REG_EVENT_MASK 8'h10
`define REG_LIVE 8'h14
// ************************************
// Control register fields
// ************************************
`define CTRL_CLOCK_SEL_BIT 0
`define CTRL_SW_RESET_BIT 1
`define CTRL_WDOG_LOCK_BIT 2
// ************************************
// Source bit positions
// ************************************
`define SRC_SUPPLY 0
`define SRC_WATCHDOG 1
`define SRC_MISSING_CLOCK 2
`define SRC_COMPARATOR 3
`define SRC_SOFTWARE 4
`define SRC_CONVERSION 5
`define SRC_PIN 6
`define SRC_COUNT 7
// ************************************
// Reset values and timing
// ************************************
`define SOURCE_ENABLE_RESET 7'h7F
`define EVENT_MASK_RESET 7'h00
`define STRETCH_TIME_NS 100
`define CLOCK_PERIOD_NS 10
`define STRETCH_CYCLES (`STRETCH_TIME_NS / `CLOCK_PERIOD_NS)
`endif

/* verification/board_reset_model.sv */
`timescale 1ns/1ns
`default_nettype none
module board_reset_model
(
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe_n,
   input wire logic push_low,
   output logic pin_level
);
   // Pull-up wins only when no party pulls the wire down
   assign pin_level = (push_low || !reset_pin_oe_n && !reset_pin_out) ?
      1'b0 : 1'b1;
endmodule
`default_nettype wire

/* verification/reset_and_clock_source_control_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ************************************
// Reset and clock checks
// ************************************
module reset_and_clock_source_control_asserts
(
   input wire logic clock,
   input wire logic srst,
   input wire logic power_on_reset,
   input wire logic supply_monitor_enable_pin,
   input wire logic supply_low,
   input wire logic reset_pin_in,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe_n,
   input wire logic system_reset,
   input wire logic watchdog_enable,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // Inputs pass a two-stage synchroniser, so allow the lag
   sequence supply_held;
      (supply_monitor_enable_pin && supply_low) [*5];
   endsequence
   sequence pin_held;
      !reset_pin_in [*5];
   endsequence
   a_supply_reset: assert property (supply_held |-> system_reset)
      else $error("supply reset missed");
   a_pin_reset: assert property (pin_held |-> system_reset)
      else $error("pin reset missed");
   a_pin_drive: assert property (power_on_reset [*2] |->
      !reset_pin_oe_n && !reset_pin_out) else $error("pin not driven");
   a_pin_release: assert property (!power_on_reset [*2] |->
      reset_pin_oe_n) else $error("pin driven idle");
   a_stretch_hold: assert property ($fell(system_reset) |->
      $past(system_reset, 8)) else $error("reset too short");
   a_wdog_por: assert property (power_on_reset [*6] |->
      watchdog_enable) else $error("watchdog off after power-up");
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o) else $error("ack late");
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
endmodule
bind reset_and_clock_source_control reset_and_clock_source_control_asserts
   chk (.clock(clock), .srst(srst), .power_on_reset(power_on_reset),
   .supply_monitor_enable_pin(supply_monitor_enable_pin),
   .supply_low(supply_low), .reset_pin_in(reset_pin_in),
   .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
   .system_reset(system_reset), .watchdog_enable(watchdog_enable),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

/* verification/reset_and_clock_source_control_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "reset_clock_consts.vh"
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin \
mismatches++; $display("ERROR %s exp %h got %h", nm, e, a); end end
module reset_and_clock_source_control_test;
   logic clock = 0, srst = 1, por = 1, smen = 1, cyc = 0, stb = 0, we = 0;
   logic ack, sysr, ext, wde, irq, pout, poe, pin;
   logic [6:0] act = 7'h00;
   logic [7:0] adr = 8'h00;
   logic [31:0] dwr = 32'h0000_0000, drd, rd;
   int mismatches = 0, samples_checked = 0, n;
   always #5 clock = ~clock;
   board_reset_model brd (.reset_pin_out(pout), .reset_pin_oe_n(poe),
      .push_low(act[6]), .pin_level(pin));
   reset_and_clock_source_control dut (.clock(clock), .srst(srst),
      .power_on_reset(por), .supply_monitor_enable_pin(smen),
      .supply_low(act[0]), .watchdog_expired(act[1]),
      .missing_clock(act[2]), .comparator_zero(act[3]),
      .conversion_start_pin_zero(act[5]), .reset_pin_in(pin),
      .reset_pin_out(pout), .reset_pin_oe_n(poe), .system_reset(sysr),
      .clock_select_external(ext), .watchdog_enable(wde), .interrupt(irq),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack));
   task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      {cyc, stb, we, adr, dwr} <= {2'b11, w, a, d};
      for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clock);
      if (ack !== 1'b1) mismatches++;
      rd = drd;
      {cyc, stb} <= 2'b00;
      @(posedge clock);
   endtask
   task settle(input int c);
      repeat (c) @(posedge clock);
      for (n = 0; n < 60 && sysr !== 1'b0; n++) @(posedge clock);
      `CHK("released", 1'b0, sysr)
   endtask
   // Stretch must outlast the source by ten cycles
   task fire(input int b, input logic [31:0] en, input logic hit);
      bus(`REG_SOURCE_ENABLE, 1'b1, en);
      act <= 7'h01 << b;
      repeat (6) @(posedge clock);
      act <= 7'h00;
      repeat (10) @(posedge clock);
      `CHK("held", hit, sysr)
      settle(0);
      bus(`REG_SOURCE_STATUS, 1'b0, 32'h0000_0000);
      if (hit) `CHK("cause", 32'h0000_0001 << b, rd)
   endtask
   task t_clock();
      bus(`REG_CONTROL, 1'b1, 32'h0000_0001);
      `CHK("external", 1'b1, ext)
      bus(`REG_CONTROL, 1'b1, 32'h0000_0003);
      settle(2);
      `CHK("internal", 1'b0, ext)
      bus(`REG_SOURCE_STATUS, 1'b0, 32'h0000_0000);
      `CHK("sw cause", 32'h0000_0010, rd)
   endtask
   task t_irq();
      bus(`REG_EVENT_MASK, 1'b1, 32'h0000_007F);
      `CHK("irq set", 1'b1, irq)
      bus(`REG_EVENT_STATUS, 1'b1, 32'h0000_007F);
      `CHK("irq clear", 1'b0, irq)
   endtask
   // Lock survives a plain reset, only power-up clears it
   task t_wdog();
      bus(`REG_CONTROL, 1'b1, 32'h0000_0004);
      for (int k = 0; k < 3; k++)
      begin
         bus(`REG_SOURCE_ENABLE, 1'b1, 32'h0000_007D);
         `CHK("watchdog", k < 2, wde)
         {srst, por} <= {k == 0, k == 1};
         repeat (8) @(posedge clock);
         {srst, por} <= 2'b00;
         settle(2);
      end
   endtask
   task stop_test();
      if (mismatches == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clock);
      mismatches++;
      stop_test();
   end
   initial
   begin
      repeat (5) @(posedge clock);
      {srst, por} <= 2'b00;
      settle(2);
      t_clock();
      for (int b = 1; b < 7; b++)
         if (b != 4)
            fire(b, 32'h0000_007F, 1'b1);
      fire(2, 32'h0000_007B, 1'b0);
      fire(6, 32'h0000_0000, 1'b1);
      fire(0, 32'h0000_0000, 1'b1);
      smen <= 1'b0;
      fire(0, 32'h0000_007F, 1'b0);
      smen <= 1'b1;
      t_irq();
      t_wdog();
      stop_test();
   end
endmodule
`default_nettype wire
